// *** logic/fsp_serial_port.sv ***
`timescale 1ns/1ps
// Functional notes
// - Mode 00 is a shift register; data on rxd pin, shift clock on txd.
// - Mode 0 transmit starts on buffer write, eight bits, LSB first.
// - Mode 0 receive starts when receive enable is 1 and receive flag 0.
// - Mode 0 bit rate is core clock divided by 12.
// - Mode 01 frames: start 0, eight data bits LSB first, stop 1.
// - Mode 1 buffer write loads a 1 into the ninth shift position.
// - Async receive starts on falling rxd edge; start bit dropped, eight bits shifted in mode 1, nine in modes 2 and 3.
// - Mode 1 end: byte to buffer, stop bit to ninth flag, receive flag set.
// - Completion only if receive flag 0 and stop bit 1; else frame lost.
// - Mode 10 frames: start, eight data, programmable ninth bit, stop.
// - Mode 2 rate is clock/64, or clock/32 with doubling bit.
// - Nine-bit transmit loads byte and ninth bit, starts at next rate tick.
// - Async transmit flag set when stop bit first appears on txd.
// - Nine-bit receive stores ninth bit, loads byte, sets flag under same conditions.
// - Mode 11 is mode 2 with timer-derived rate.
// - Any buffer write with byte lane 0 enabled starts transmit; async receive needs receive enable.
// - Variable rate from timer 1 or timer 2, separately for transmit and receive.
// - Timer 1 rate is overflow rate times 2^doubling over 32.
// - Multiprocessor bit: nine-bit frames with ninth bit 0 raise no flag.
// - Sixteen rate ticks make one bit.

module fsp_serial_port (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic timer1_overflow,
  input wire logic timer2_overflow,
  input wire logic rxd_in,
  output logic rxd_out,
  output logic rxd_oe,
  output logic txd
);

  fsp_pkg::fsp_state_t s;
  fsp_pkg::fsp_state_t n;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic fsp_pkg::fsp_sel_t decode(input logic [7:0] addr);
    if (addr == fsp_pkg::CONTROL_OFFSET) begin
      return fsp_pkg::FSP_SEL_CTRL;
    end else if (addr == fsp_pkg::BUFFER_OFFSET) begin
      return fsp_pkg::FSP_SEL_BUF;
    end else if (addr == fsp_pkg::RATE_OFFSET) begin
      return fsp_pkg::FSP_SEL_RATE;
    end
    return fsp_pkg::FSP_SEL_NONE;
  endfunction

  // Fixed rate in mode 2, else the selected timer
  function automatic logic pick_tick(input logic [1:0] mode, input logic use_t2, input logic fix,
                                     input logic t1, input logic t2);
    if (mode == 2'h2) begin
      return fix;
    end
    return use_t2 ? t2 : t1;
  endfunction

  always_comb begin
    logic [1:0] mode;
    logic nine;
    logic dbl;
    logic fix_tick;
    logic t1_tick;
    logic tx_en;
    logic rx_en;
    logic wr_fire;
    logic buf_wr;
    logic sample;
    logic [7:0] r_data;
    logic r_ninth;
    logic ok;
    logic ti_set;
    logic ri_set;
    fsp_pkg::fsp_sel_t wsel;
    fsp_pkg::fsp_sel_t rsel;
    mode = s.ctrl[fsp_pkg::CTRL_MODE_HI:fsp_pkg::CTRL_MODE_LO];
    nine = s.ctrl[fsp_pkg::CTRL_MODE_HI];
    dbl = s.rate[fsp_pkg::RATE_DOUBLE];
    fix_tick = 1'b0;
    t1_tick = 1'b0;
    tx_en = 1'b0;
    rx_en = 1'b0;
    wr_fire = 1'b0;
    buf_wr = 1'b0;
    sample = s.sync[1];
    r_data = 8'h00;
    r_ninth = 1'b0;
    ok = 1'b0;
    ti_set = 1'b0;
    ri_set = 1'b0;
    wsel = decode(s.aw_addr);
    rsel = decode(araddr);
    n = s;

    // ****************************************************************
    // Pin synchroniser; only the second stage is read
    // ****************************************************************
    n.sync = {s.sync[0], rxd_in};
    n.rx_prev = s.sync[1];

    // ****************************************************************
    // Rate ticks, sixteen per bit
    // ****************************************************************
    if (s.fix_cnt == (dbl ? fsp_pkg::FIXED_DIV_FAST_LAST : fsp_pkg::FIXED_DIV_SLOW_LAST)) begin
      n.fix_cnt = 2'h0;
      fix_tick = 1'b1;
    end else begin
      n.fix_cnt = s.fix_cnt + 2'h1;
    end
    // Halving timer 1 unless doubled gives overflow*2^d/32 per bit
    if (timer1_overflow) begin
      n.t1_half = ~s.t1_half;
    end
    t1_tick = timer1_overflow & (dbl | s.t1_half);
    tx_en = pick_tick(mode, s.rate[fsp_pkg::RATE_TX_T2], fix_tick, t1_tick, timer2_overflow);
    rx_en = pick_tick(mode, s.rate[fsp_pkg::RATE_RX_T2], fix_tick, t1_tick, timer2_overflow);

    // ****************************************************************
    // AXI4-Lite write channel
    // ****************************************************************
    if (awvalid && s.awready) begin
      n.aw_held = 1'b1;
      n.aw_addr = awaddr;
    end
    if (wvalid && s.wready) begin
      n.w_held = 1'b1;
      n.w_data = wdata[7:0];
      n.w_lane0 = wstrb[0];
    end
    if (s.bvalid && bready) begin
      n.bvalid = 1'b0;
    end
    wr_fire = s.aw_held && s.w_held && !s.bvalid;
    if (wr_fire) begin
      n.aw_held = 1'b0;
      n.w_held = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = (wsel == fsp_pkg::FSP_SEL_NONE) ? fsp_pkg::RESP_SLVERR : fsp_pkg::RESP_OKAY;
      if (s.w_lane0) begin
        case (wsel)
          fsp_pkg::FSP_SEL_CTRL: begin
            n.ctrl = s.w_data;
          end
          fsp_pkg::FSP_SEL_BUF: begin
            buf_wr = 1'b1;
          end
          fsp_pkg::FSP_SEL_RATE: begin
            n.rate = s.w_data[2:0];
          end
          default: begin
          end
        endcase
      end
    end
    n.awready = !n.aw_held && !n.bvalid;
    n.wready = !n.w_held && !n.bvalid;

    // ****************************************************************
    // AXI4-Lite read channel
    // ****************************************************************
    if (s.rvalid && rready) begin
      n.rvalid = 1'b0;
      n.arready = 1'b1;
    end
    if (arvalid && s.arready) begin
      n.arready = 1'b0;
      n.rvalid = 1'b1;
      n.rresp = fsp_pkg::RESP_OKAY;
      case (rsel)
        fsp_pkg::FSP_SEL_CTRL: begin
          n.rdata = {24'h000000, s.ctrl};
        end
        fsp_pkg::FSP_SEL_BUF: begin
          n.rdata = {24'h000000, s.rx_buf};
        end
        fsp_pkg::FSP_SEL_RATE: begin
          n.rdata = {29'h00000000, s.rate};
        end
        default: begin
          n.rdata = 32'h00000000;
          n.rresp = fsp_pkg::RESP_SLVERR;
        end
      endcase
    end

    // ****************************************************************
    // Mode 0 shift register
    // ****************************************************************
    if (buf_wr && mode == 2'h0) begin
      n.m0_act = 1'b1;
      n.m0_rx = 1'b0;
      n.m0_div = 4'h0;
      n.m0_bit = 3'h0;
      n.m0_shift = s.w_data;
    end else if (!s.m0_act && mode == 2'h0 && s.ctrl[fsp_pkg::CTRL_REN] && !s.ctrl[fsp_pkg::CTRL_RI]) begin
      n.m0_act = 1'b1;
      n.m0_rx = 1'b1;
      n.m0_div = 4'h0;
      n.m0_bit = 3'h0;
    end else if (s.m0_act) begin
      n.m0_div = s.m0_div + 4'h1;
      if (s.m0_rx && s.m0_div == fsp_pkg::SHIFT_RISE) begin
        n.m0_shift = {sample, s.m0_shift[7:1]};
      end
      if (s.m0_div == fsp_pkg::SHIFT_DIV_LAST) begin
        n.m0_div = 4'h0;
        n.m0_bit = s.m0_bit + 3'h1;
        if (!s.m0_rx) begin
          n.m0_shift = {1'b0, s.m0_shift[7:1]};
        end
        if (s.m0_bit == 3'h7) begin
          n.m0_act = 1'b0;
          if (s.m0_rx) begin
            ri_set = 1'b1;
            n.rx_buf = s.m0_shift;
          end else begin
            ti_set = 1'b1;
          end
        end
      end
    end
    // Clock low for the first half of each bit, high for the second
    n.rxd_oe = n.m0_act && !n.m0_rx;
    n.rxd_out = n.m0_shift[0];
    n.txd = 1'b1;

    // ****************************************************************
    // Asynchronous transmitter
    // ****************************************************************
    if (buf_wr && mode != 2'h0) begin
      n.tx_pend = 1'b1;
      n.tx_st = fsp_pkg::FSP_TX_IDLE;
      n.tx_shift = {nine ? s.ctrl[fsp_pkg::CTRL_TB8] : 1'b1, s.w_data};
    end else begin
      case (s.tx_st)
        fsp_pkg::FSP_TX_IDLE: begin
          if (s.tx_pend && tx_en) begin
            n.tx_pend = 1'b0;
            n.tx_st = fsp_pkg::FSP_TX_RUN;
            n.tx_tick = 4'h0;
            n.tx_bit = 4'h0;
          end
        end
        fsp_pkg::FSP_TX_RUN: begin
          if (tx_en) begin
            n.tx_tick = s.tx_tick + 4'h1;
            if (s.tx_tick == fsp_pkg::TICK_LAST) begin
              if (s.tx_bit == (nine ? fsp_pkg::STOP_BIT_NINE : fsp_pkg::STOP_BIT_EIGHT)) begin
                n.tx_st = fsp_pkg::FSP_TX_IDLE;
              end else begin
                n.tx_bit = s.tx_bit + 4'h1;
                // Leaving the start bit must not drop data bit 0
                n.tx_shift = (s.tx_bit == 4'h0) ? s.tx_shift : {1'b1, s.tx_shift[8:1]};
                if (n.tx_bit == (nine ? fsp_pkg::STOP_BIT_NINE : fsp_pkg::STOP_BIT_EIGHT)) begin
                  ti_set = 1'b1;
                end
              end
            end
          end
        end
        default: begin
          n.tx_st = fsp_pkg::FSP_TX_IDLE;
        end
      endcase
    end
    // Next-state view keeps the clock low from the first cycle and idle after the last
    if (n.m0_act) begin
      n.txd = (n.m0_div >= fsp_pkg::SHIFT_RISE);
    end else if (n.tx_st == fsp_pkg::FSP_TX_RUN) begin
      n.txd = (n.tx_bit == 4'h0) ? 1'b0 : n.tx_shift[0];
    end

    // ****************************************************************
    // Asynchronous receiver
    // ****************************************************************
    case (s.rx_st)
      fsp_pkg::FSP_RX_IDLE: begin
        if (mode != 2'h0 && s.ctrl[fsp_pkg::CTRL_REN] && s.rx_prev && !sample) begin
          n.rx_st = fsp_pkg::FSP_RX_START;
          n.rx_tick = 4'h0;
        end
      end
      fsp_pkg::FSP_RX_START: begin
        if (rx_en) begin
          n.rx_tick = s.rx_tick + 4'h1;
          if (s.rx_tick == fsp_pkg::START_SAMPLE) begin
            n.rx_tick = 4'h0;
            n.rx_bit = 4'h0;
            n.rx_st = sample ? fsp_pkg::FSP_RX_IDLE : fsp_pkg::FSP_RX_DATA;
          end
        end
      end
      fsp_pkg::FSP_RX_DATA: begin
        if (rx_en) begin
          n.rx_tick = s.rx_tick + 4'h1;
          if (s.rx_tick == fsp_pkg::TICK_LAST) begin
            if (s.rx_bit == (nine ? fsp_pkg::LAST_SAMPLE_NINE : fsp_pkg::LAST_SAMPLE_EIGHT)) begin
              n.rx_st = fsp_pkg::FSP_RX_IDLE;
              // Final sample is the stop bit in every async mode
              r_data = nine ? s.rx_shift[7:0] : s.rx_shift[8:1];
              r_ninth = nine ? s.rx_shift[8] : sample;
              ok = !s.ctrl[fsp_pkg::CTRL_RI] && sample
                   && (!s.ctrl[fsp_pkg::CTRL_MP] || !nine || r_ninth);
              if (ok) begin
                n.rx_buf = r_data;
                ri_set = 1'b1;
              end
            end else begin
              n.rx_bit = s.rx_bit + 4'h1;
              n.rx_shift = {sample, s.rx_shift[8:1]};
            end
          end
        end
      end
      default: begin
        n.rx_st = fsp_pkg::FSP_RX_IDLE;
      end
    endcase

    // ****************************************************************
    // Flag sets win over a software write in the same cycle
    // ****************************************************************
    if (ok) begin
      n.ctrl[fsp_pkg::CTRL_RB8] = r_ninth;
    end
    if (ri_set) begin
      n.ctrl[fsp_pkg::CTRL_RI] = 1'b1;
    end
    if (ti_set) begin
      n.ctrl[fsp_pkg::CTRL_TI] = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
      s.ctrl <= fsp_pkg::CONTROL_RESET;
      s.rx_buf <= fsp_pkg::BUFFER_RESET;
      s.rate <= fsp_pkg::RATE_RESET;
      s.awready <= 1'b1;
      s.wready <= 1'b1;
      s.arready <= 1'b1;
      s.sync <= 2'h3;
      s.rx_prev <= 1'b1;
      s.txd <= 1'b1;
      s.tx_st <= fsp_pkg::FSP_TX_IDLE;
      s.rx_st <= fsp_pkg::FSP_RX_IDLE;
    end else begin
      s <= n;
    end
  end

  assign awready = s.awready;
  assign wready = s.wready;
  assign bvalid = s.bvalid;
  assign bresp = s.bresp;
  assign arready = s.arready;
  assign rvalid = s.rvalid;
  assign rdata = s.rdata;
  assign rresp = s.rresp;
  assign txd = s.txd;
  assign rxd_out = s.rxd_out;
  assign rxd_oe = s.rxd_oe;

endmodule // fsp_serial_port

// *** shared/fsp_pkg.sv ***
package fsp_pkg;

  // ****************************************************************
  // Register map (byte addresses)
  // ****************************************************************
  localparam logic [7:0] CONTROL_OFFSET = 8'h00;
  localparam logic [7:0] BUFFER_OFFSET = 8'h04;
  localparam logic [7:0] RATE_OFFSET = 8'h08;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int CTRL_MODE_HI = 7;
  localparam int CTRL_MODE_LO = 6;
  localparam int CTRL_MP = 5;
  localparam int CTRL_REN = 4;
  localparam int CTRL_TB8 = 3;
  localparam int CTRL_RB8 = 2;
  localparam int CTRL_TI = 1;
  localparam int CTRL_RI = 0;
  localparam int RATE_DOUBLE = 0;
  localparam int RATE_TX_T2 = 1;
  localparam int RATE_RX_T2 = 2;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] BUFFER_RESET = 8'h00;
  localparam logic [2:0] RATE_RESET = 3'h0;

  // ****************************************************************
  // Cycle counts
  // ****************************************************************
  localparam logic [3:0] SHIFT_DIV_LAST = 4'hb;
  localparam logic [3:0] SHIFT_RISE = 4'h6;
  localparam logic [3:0] TICK_LAST = 4'hf;
  localparam logic [3:0] START_SAMPLE = 4'h7;
  localparam logic [1:0] FIXED_DIV_SLOW_LAST = 2'h3;
  localparam logic [1:0] FIXED_DIV_FAST_LAST = 2'h1;
  localparam logic [3:0] LAST_SAMPLE_EIGHT = 4'h8;
  localparam logic [3:0] LAST_SAMPLE_NINE = 4'h9;
  localparam logic [3:0] STOP_BIT_EIGHT = 4'h9;
  localparam logic [3:0] STOP_BIT_NINE = 4'ha;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {FSP_SEL_CTRL, FSP_SEL_BUF, FSP_SEL_RATE, FSP_SEL_NONE} fsp_sel_t;
  typedef enum logic {FSP_TX_IDLE, FSP_TX_RUN} fsp_tx_t;
  typedef enum logic [1:0] {FSP_RX_IDLE, FSP_RX_START, FSP_RX_DATA} fsp_rx_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr;
    logic [7:0] w_data;
    logic w_lane0;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [7:0] ctrl;
    logic [7:0] rx_buf;
    logic [2:0] rate;
    logic [1:0] sync;
    logic rx_prev;
    logic t1_half;
    logic [1:0] fix_cnt;
    fsp_tx_t tx_st;
    logic tx_pend;
    logic [3:0] tx_tick;
    logic [3:0] tx_bit;
    logic [8:0] tx_shift;
    fsp_rx_t rx_st;
    logic [3:0] rx_tick;
    logic [3:0] rx_bit;
    logic [8:0] rx_shift;
    logic m0_act;
    logic m0_rx;
    logic [3:0] m0_div;
    logic [2:0] m0_bit;
    logic [7:0] m0_shift;
    logic txd;
    logic rxd_out;
    logic rxd_oe;
  } fsp_state_t;

endpackage

// *** testbench/fsp_remote_end.sv ***
`timescale 1ns/1ps
module fsp_remote_end (
  input wire logic aclk,
  input wire logic txd,
  input wire logic [7:0] tx_period,
  input wire logic [3:0] tx_bits,
  input wire logic m0_on,
  input wire logic [7:0] m0_word,
  output logic rxd,
  output logic got,
  output logic [9:0] got_word
);
  logic [2:0] m0_i = 3'h0;

  initial begin
    rxd = 1'b1;
    got = 1'b0;
    got_word = 10'h000;
  end

  // Mid-bit sampling, like a real receiver; zero bits means not listening
  always begin : capture
    @(negedge txd);
    if (tx_bits != 4'h0) begin
      repeat (tx_period / 2) @(posedge aclk);
      for (int i = 0; i < tx_bits; i++) begin
        repeat (tx_period) @(posedge aclk);
        got_word[i] <= txd;
      end
      got <= 1'b1;
      @(posedge aclk);
      got <= 1'b0;
    end
  end

  // Shift partner: next bit on each falling shift clock, LSB first
  always @(negedge txd) begin : shift_feed
    if (m0_on) begin
      rxd <= m0_word[m0_i];
      m0_i <= m0_i + 3'h1;
    end
  end

  // Start low, then bits LSB first; line rests high afterwards
  task automatic send(input logic [9:0] w, input int nbits, input int period);
    rxd <= 1'b0;
    repeat (period) @(posedge aclk);
    for (int i = 0; i < nbits; i++) begin
      rxd <= w[i];
      repeat (period) @(posedge aclk);
    end
    rxd <= 1'b1;
  endtask
endmodule // fsp_remote_end

// *** testbench/fsp_serial_port_bench.sv ***
`timescale 1ns/1ps
module fsp_serial_port_bench;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, tdiv = 8'h00, tx_period = 8'h00, m0_w;
  logic [31:0] wdata = 32'h0, rdata, rnd = 32'h9c782304;
  logic [3:0] wstrb = 4'hf, tx_bits = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic timer1_overflow = 1'b0, timer2_overflow = 1'b0, txd_q = 1'b1, m0_on = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, rxd_in, rxd_out, rxd_oe, txd, got;
  logic [1:0] bresp, rresp;
  logic [9:0] got_word, w;
  int n_errors = 0, check_count = 0, m0_n = 0, nb;
  logic [33:0] exp_rd[$];
  logic [1:0] exp_b[$];
  logic [9:0] exp_tx[$];
  // Transmit cases: shift, mode 1 timer 1, mode 2 doubled, mode 3 timer 2
  logic [7:0] txr[4] = '{8'h00, 8'h00, 8'h01, 8'h02}, txc[4] = '{8'h00, 8'h40, 8'h88, 8'hc0};
  logic [7:0] txp[4] = '{8'd0, 8'd64, 8'd32, 8'd32};
  logic [3:0] txb[4] = '{4'd0, 4'd9, 4'd10, 4'd10};
  logic [1:0] txe[4] = '{2'b00, 2'b01, 2'b11, 2'b10};
  logic [7:0] rxr[3] = '{8'h00, 8'h01, 8'h04}, rxc[3] = '{8'h50, 8'h90, 8'hd0}, rxp[3] = '{8'd64, 8'd32, 8'd32};

  always #12.5 aclk = ~aclk;

  fsp_serial_port uut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .timer1_overflow(timer1_overflow), .timer2_overflow(timer2_overflow),
    .rxd_in(rxd_in), .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd(txd));

  fsp_remote_end far_end (.aclk(aclk), .txd(txd), .tx_period(tx_period), .tx_bits(tx_bits), .rxd(rxd_in),
    .m0_on(m0_on), .m0_word(rnd[7:0]), .got(got), .got_word(got_word));

  // ****************************************************************
  // Checking
  // ****************************************************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check_word(input string name, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", name, e, g);
    end
  endtask

  task automatic check_frame(input logic [9:0] e, input logic [9:0] g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH frame expected %h seen %h", e, g);
    end
  endtask

  task final_report;
    if (n_errors == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Timers as auto-reload sources, one overflow every second cycle
  always @(posedge aclk) begin
    tdiv <= tdiv + 8'h01;
    timer1_overflow <= tdiv[0];
    timer2_overflow <= tdiv[0];
  end

  always @(posedge aclk) begin : watch
    logic [33:0] e;
    if (rvalid && rready) begin
      e = exp_rd.pop_front();
      check_word("rdata", e[31:0], rdata);
      check_word("rresp", {30'h0, e[33:32]}, {30'h0, rresp});
    end
    if (bvalid && bready) check_word("bresp", {30'h0, exp_b.pop_front()}, {30'h0, bresp});
    if (got) check_frame(exp_tx.pop_front(), got_word);
    txd_q <= txd;
    // Shift data is taken at the rising shift clock
    if (rxd_oe && !txd_q && txd) begin
      m0_w = {rxd_out, m0_w[7:1]};
      m0_n++;
      if (m0_n == 8) begin
        m0_n = 0;
        check_frame(exp_tx.pop_front(), {2'b00, m0_w});
      end
    end
  end

  // ****************************************************************
  // Bus master
  // ****************************************************************
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r = 2'h0);
    exp_b.push_back(r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) bready <= 1'b0;
    end while (!bvalid);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r = 2'h0);
    exp_rd.push_back({r, 24'h0, d});
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) rready <= 1'b0;
    end while (!rvalid);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd(fsp_pkg::CONTROL_OFFSET, 8'h00);
    rd(fsp_pkg::BUFFER_OFFSET, 8'h00);
    rd(fsp_pkg::RATE_OFFSET, 8'h00);
    rd(8'h0c, 8'h00, fsp_pkg::RESP_SLVERR);
    wr(8'h0c, 8'hff, fsp_pkg::RESP_SLVERR);
    // Lane 0 off: the write is answered but changes nothing
    wstrb <= 4'h0;
    wr(fsp_pkg::CONTROL_OFFSET, 8'hff);
    wstrb <= 4'hf;
    rd(fsp_pkg::CONTROL_OFFSET, 8'h00);
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      wr(fsp_pkg::RATE_OFFSET, txr[i]);
      wr(fsp_pkg::CONTROL_OFFSET, txc[i]);
      tx_period <= txp[i];
      tx_bits <= txb[i];
      exp_tx.push_back({txe[i], rnd[7:0]});
      wr(fsp_pkg::BUFFER_OFFSET, rnd[7:0]);
      wait (exp_tx.size() == 0);
      // Let the stop bit finish before the mode changes
      repeat (40) @(posedge aclk);
      rd(fsp_pkg::CONTROL_OFFSET, txc[i] | 8'h02);
      wr(fsp_pkg::CONTROL_OFFSET, txc[i]);
    end
    tx_bits <= 4'h0;
    for (int i = 0; i < 3; i++) begin
      rnd = lfsr(rnd);
      w = (i == 0) ? {2'b01, rnd[7:0]} : {1'b1, rnd[8], rnd[7:0]};
      nb = (i == 0) ? 9 : 10;
      wr(fsp_pkg::RATE_OFFSET, rxr[i]);
      wr(fsp_pkg::CONTROL_OFFSET, rxc[i]);
      far_end.send(w, nb, rxp[i]);
      rd(fsp_pkg::BUFFER_OFFSET, w[7:0]);
      rd(fsp_pkg::CONTROL_OFFSET, rxc[i] | 8'h01 | {5'h0, w[8], 2'h0});
      rnd = lfsr(rnd);
      far_end.send({2'b11, rnd[7:0]}, nb, rxp[i]);
      rd(fsp_pkg::BUFFER_OFFSET, w[7:0]);
      wr(fsp_pkg::CONTROL_OFFSET, rxc[i] | 8'h20);
      // Stop bit low in mode 1, ninth bit low in the nine-bit modes
      far_end.send({2'b10, rnd[7:0]}, nb, rxp[i]);
      rd(fsp_pkg::CONTROL_OFFSET, rxc[i] | 8'h20);
      rd(fsp_pkg::BUFFER_OFFSET, w[7:0]);
    end
    // Shift-register receive; partner feeds a random byte
    rnd = lfsr(rnd);
    m0_on <= 1'b1;
    wr(fsp_pkg::CONTROL_OFFSET, 8'h10);
    repeat (110) @(posedge aclk);
    rd(fsp_pkg::BUFFER_OFFSET, rnd[7:0]);
    rd(fsp_pkg::CONTROL_OFFSET, 8'h11);
    final_report;
  end

  initial begin
    repeat (40000) @(posedge aclk);
    n_errors++;
    final_report;
  end
endmodule // fsp_serial_port_bench

// *** testbench/fsp_serial_port_checker.sv ***
`timescale 1ns/1ps
module fsp_serial_port_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rxd_out,
  input wire logic rxd_oe,
  input wire logic txd
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic [7:0] oe_cnt;
  logic wr_take;
  assign wr_take = awvalid && awready && wvalid && wready;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      oe_cnt <= 8'h00;
    end else begin
      oe_cnt <= rxd_oe ? oe_cnt + 8'h01 : 8'h00;
    end
  end

  property p_oe_start_low;
    $rose(rxd_oe) |-> !txd;
  endproperty
  a_oe_start_low: assert property (p_oe_start_low) else $error("shift clock not low at start");

  property p_clk_low;
    $fell(txd) && rxd_oe |-> (!txd) [*6] ##1 txd;
  endproperty
  a_clk_low: assert property (p_clk_low) else $error("shift clock low phase wrong");

  property p_clk_high;
    $rose(txd) && rxd_oe |-> txd [*6];
  endproperty
  a_clk_high: assert property (p_clk_high) else $error("shift clock high phase short");

  property p_data_stable;
    rxd_oe && $past(rxd_oe) && $changed(rxd_out) |-> $fell(txd);
  endproperty
  a_data_stable: assert property (p_data_stable) else $error("shift data moved mid bit");

  property p_oe_len;
    $fell(rxd_oe) |-> oe_cnt == 8'd96;
  endproperty
  a_oe_len: assert property (p_oe_len) else $error("shift frame not eight bits");

  property p_write_starts;
    wr_take && awaddr == fsp_pkg::BUFFER_OFFSET && wstrb[0] |-> ##[1:40] !txd;
  endproperty
  a_write_starts: assert property (p_write_starts) else $error("buffer write sent nothing");

  property p_resp;
    wr_take |-> ##[1:2] bvalid;
  endproperty
  a_resp: assert property (p_resp) else $error("write response late");

  property p_read;
    arvalid && arready |-> ##[1:2] rvalid;
  endproperty
  a_read: assert property (p_read) else $error("read answer late");
endmodule // fsp_serial_port_checker

bind fsp_serial_port fsp_serial_port_checker chk (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
  .awvalid(awvalid), .awready(awready), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bvalid(bvalid),
  .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd(txd));
